// ### hw/rmsc_defs.vh
// Constants for the reset and operating-mode control block
`ifndef RMSC_DEFS_VH
`define RMSC_DEFS_VH

// ----------------------------------------------------------------
// Register offsets (byte addresses, 8-bit bus address)
// ----------------------------------------------------------------
`define RMSC_ADDR_CTRL      8'h00
`define RMSC_ADDR_STATUS    8'h04

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define RMSC_CTRL_CLKOUT_GPIO   0
`define RMSC_CTRL_USE_MASTER    1
`define RMSC_CTRL_PCLK_EN       2
`define RMSC_CTRL_WIDTH         3
`define RMSC_CTRL_RESET         3'h0

// ----------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------
`define RMSC_STAT_MODE_LO       0
`define RMSC_STAT_BOOT_8BIT     2
`define RMSC_STAT_TRISTATE      3
`define RMSC_STAT_PORT_SEL      4
`define RMSC_STAT_CAUSE_EXT     5
`define RMSC_STAT_CAUSE_WDOG    6
`define RMSC_STAT_IN_RESET      7
`define RMSC_STAT_ICE_MODE      8

// ----------------------------------------------------------------
// Operating modes {op_select0, op_select1}
// ----------------------------------------------------------------
`define RMSC_MODE_ONCHIP_OSC    2'h0
`define RMSC_MODE_BSCAN         2'h1
`define RMSC_MODE_EXT_CLOCK     2'h2
`define RMSC_MODE_TEST          2'h3

// ----------------------------------------------------------------
// Timing counts in slow-clock cycles
// ----------------------------------------------------------------
`define RMSC_STRAP_WINDOW       10
`define RMSC_WDOG_HOLD          4'hA

// ----------------------------------------------------------------
// Bus responses
// ----------------------------------------------------------------
`define RMSC_RESP_OKAY          2'h0
`define RMSC_RESP_SLVERR        2'h2

`endif

// ### hw/rmsc_rst_sync.v
// Reset release synchroniser: asynchronous entry, release on slow-clock edges
`timescale 1ns/1ps
`default_nettype none

module rmsc_rst_sync
(
    // Clock and resets
    input  wire clk,
    input  wire arst_n,
    input  wire srst,
    // Slow clock rising-edge strobe
    input  wire slow_edge,
    // Released level, low while held
    output wire released
);

    reg stage1_q;
    reg stage2_q;

    // Entry is immediate on the pin; release walks two slow-clock stages
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            stage1_q <= 1'b0;
            stage2_q <= 1'b0;
        end
        else if (srst)
        begin
            stage1_q <= 1'b0;
            stage2_q <= 1'b0;
        end
        else if (slow_edge)
        begin
            stage1_q <= 1'b1;
            stage2_q <= stage1_q;
        end
    end

    assign released = stage2_q;

endmodule

`default_nettype wire

// ### hw/rmsc_top.v
// Chip reset, operating-mode decode, strap capture and test-reset routing
//
// Our own choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "rmsc_defs.vh"

module rmsc_top
(
    // Clock and power-on reset
    input  wire        CLK,
    input  wire        RESET,
    // Board pins
    input  wire        EXT_RESET_N,
    input  wire        TEST_PORT_RESET_N,
    input  wire        OP_SELECT0,
    input  wire        OP_SELECT1,
    input  wire        OSC_INPUT_PIN,
    input  wire        ONCHIP_OSC_CLK,
    input  wire        BOOT_WIDTH_STRAP,
    input  wire        TRISTATE_STRAP_N,
    input  wire        TEST_PORT_SELECT,
    input  wire        WDOG_RESET,
    // AXI4-Lite write channels
    input  wire [7:0]  S_AXI_AWADDR,
    input  wire        S_AXI_AWVALID,
    output reg         S_AXI_AWREADY,
    input  wire [31:0] S_AXI_WDATA,
    input  wire [3:0]  S_AXI_WSTRB,
    input  wire        S_AXI_WVALID,
    output reg         S_AXI_WREADY,
    output reg  [1:0]  S_AXI_BRESP,
    output reg         S_AXI_BVALID,
    input  wire        S_AXI_BREADY,
    // AXI4-Lite read channels
    input  wire [7:0]  S_AXI_ARADDR,
    input  wire        S_AXI_ARVALID,
    output reg         S_AXI_ARREADY,
    output reg  [31:0] S_AXI_RDATA,
    output reg  [1:0]  S_AXI_RRESP,
    output reg         S_AXI_RVALID,
    input  wire        S_AXI_RREADY,
    // Chip-level reset controls
    output reg         CPU_RESET,
    output reg         PERIPH_REG_RESET,
    output reg         EXT_BUS_ADDR_LOW,
    output reg         PERIPH_CLK_EN,
    output reg         PERIPH_IO_FORCE_INPUT,
    // Clocking
    output reg         SLOW_CLOCK,
    output reg         USE_MASTER_CLOCK,
    output reg         CLOCK_OUT_PIN,
    output reg         CLOCK_OUT_IS_GPIO,
    // Mode and strap results
    output reg         MODE_ONCHIP_OSC,
    output reg         MODE_BSCAN,
    output reg         MODE_EXT_CLOCK,
    output reg         MODE_TEST,
    output reg         ICE_MODE,
    output reg         BSCAN_INSTR_EN,
    output reg         CORE_ID_NONCOMPLIANT,
    output reg         BOOT_8BIT,
    output reg         OUTPUTS_HIZ,
    // Test access port resets
    output reg         TAP_BSCAN_RESET,
    output reg         TAP_ICE_RESET
);

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function [1:0] reg_sel;
        input [7:0] addr;
        begin
            if (addr == `RMSC_ADDR_CTRL)
                reg_sel = 2'h1;
            else if (addr == `RMSC_ADDR_STATUS)
                reg_sel = 2'h2;
            else
                reg_sel = 2'h0;
        end
    endfunction

    // ----------------------------------------------------------------
    // Slow clock selection and edge detect
    // ----------------------------------------------------------------
    wire [1:0] pin_mode = {OP_SELECT0, OP_SELECT1};
    wire       slow_lvl = (pin_mode == `RMSC_MODE_EXT_CLOCK) ?
                          OSC_INPUT_PIN : ONCHIP_OSC_CLK;
    reg        slow_q;
    wire       slow_edge = slow_lvl & ~slow_q;

    // No watchdog on the slow clock itself: a stopped clock just freezes
    always @(posedge CLK)
    begin
        if (RESET)
            slow_q <= 1'b0;
        else
            slow_q <= slow_lvl;
    end

    // ----------------------------------------------------------------
    // External reset release and watchdog reset
    // ----------------------------------------------------------------
    wire       ext_released;
    reg  [3:0] wd_cnt_q;
    reg        ext_pin_q;
    wire       ext_rise = EXT_RESET_N & ~ext_pin_q;

    rmsc_rst_sync u_rst_sync
    (
        .clk       (CLK),
        .arst_n    (EXT_RESET_N),
        .srst      (RESET),
        .slow_edge (slow_edge),
        .released  (ext_released)
    );

    always @(posedge CLK)
    begin
        if (RESET || !ext_released)
            wd_cnt_q <= 4'h0;
        else if (WDOG_RESET)
            wd_cnt_q <= `RMSC_WDOG_HOLD;
        else if (slow_edge && wd_cnt_q != 4'h0)
            wd_cnt_q <= wd_cnt_q - 4'h1;
    end

    wire in_reset = RESET | ~ext_released | (wd_cnt_q != 4'h0);

    // ----------------------------------------------------------------
    // Reset-domain outputs: set at once by the pin, cleared on release
    // ----------------------------------------------------------------
    reg [`RMSC_CTRL_WIDTH-1:0] ctrl_q;

    always @(posedge CLK or negedge EXT_RESET_N)
    begin
        if (!EXT_RESET_N)
        begin
            CPU_RESET             <= 1'b1;
            PERIPH_REG_RESET      <= 1'b1;
            EXT_BUS_ADDR_LOW      <= 1'b1;
            PERIPH_CLK_EN         <= 1'b0;
            PERIPH_IO_FORCE_INPUT <= 1'b1;
        end
        else
        begin
            CPU_RESET             <= in_reset;
            PERIPH_REG_RESET      <= in_reset;
            EXT_BUS_ADDR_LOW      <= in_reset;
            PERIPH_CLK_EN         <= ~in_reset & ctrl_q[`RMSC_CTRL_PCLK_EN];
            PERIPH_IO_FORCE_INPUT <= in_reset;
        end
    end

    // ----------------------------------------------------------------
    // Strap capture over the last slow cycles before release
    // ----------------------------------------------------------------
    reg [`RMSC_STRAP_WINDOW-1:0] boot_hist_q;
    reg [`RMSC_STRAP_WINDOW-1:0] tri_hist_q;
    reg [`RMSC_STRAP_WINDOW-1:0] fill_q;
    reg                          boot_q;
    reg                          tri_q;
    reg                          port_sel_q;
    reg [1:0]                    mode_q;
    reg                          cause_ext_q;
    reg                          cause_wd_q;

    // Histories shift on every slow edge while the pin is held low
    genvar gi;
    generate
        for (gi = 0; gi < `RMSC_STRAP_WINDOW; gi = gi + 1)
        begin : g_hist
            localparam integer prev_bit = (gi > 0) ? gi - 1 : 0;
            always @(posedge CLK)
            begin
                if (RESET || ext_rise)
                begin
                    fill_q[gi]      <= 1'b0;
                    boot_hist_q[gi] <= 1'b0;
                    tri_hist_q[gi]  <= 1'b0;
                end
                else if (!EXT_RESET_N && slow_edge)
                begin
                    fill_q[gi]      <= (gi == 0) ? 1'b1 : fill_q[prev_bit];
                    boot_hist_q[gi] <= (gi == 0) ? BOOT_WIDTH_STRAP : boot_hist_q[prev_bit];
                    tri_hist_q[gi]  <= (gi == 0) ? TRISTATE_STRAP_N : tri_hist_q[prev_bit];
                end
            end
        end
    endgenerate

    // Only the pin's rising edge updates the strap and mode latches; watchdog sets only the cause flags
    always @(posedge CLK)
    begin
        ext_pin_q <= RESET ? 1'b1 : EXT_RESET_N;
        if (RESET)
        begin
            boot_q      <= 1'b0;
            tri_q       <= 1'b0;
            port_sel_q  <= 1'b0;
            mode_q      <= `RMSC_MODE_ONCHIP_OSC;
            cause_ext_q <= 1'b1;
            cause_wd_q  <= 1'b0;
        end
        else
        begin
            if (ext_rise)
            begin
                boot_q     <= boot_hist_q[0];
                tri_q      <= (&fill_q) & ~(|tri_hist_q);
                port_sel_q <= TEST_PORT_SELECT;
                mode_q     <= pin_mode;
            end
            if (!EXT_RESET_N)
            begin
                cause_ext_q <= 1'b1;
                cause_wd_q  <= 1'b0;
            end
            else if (WDOG_RESET && ext_released)
            begin
                cause_ext_q <= 1'b0;
                cause_wd_q  <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Mode, clock and test-port outputs
    // ----------------------------------------------------------------
    always @(posedge CLK)
    begin
        if (RESET)
        begin
            SLOW_CLOCK           <= 1'b0;
            USE_MASTER_CLOCK     <= 1'b0;
            CLOCK_OUT_PIN        <= 1'b0;
            CLOCK_OUT_IS_GPIO    <= 1'b0;
            MODE_ONCHIP_OSC      <= 1'b1;
            MODE_BSCAN           <= 1'b0;
            MODE_EXT_CLOCK       <= 1'b0;
            MODE_TEST            <= 1'b0;
            ICE_MODE             <= 1'b1;
            BSCAN_INSTR_EN       <= 1'b0;
            CORE_ID_NONCOMPLIANT <= 1'b1;
            BOOT_8BIT            <= 1'b0;
            OUTPUTS_HIZ          <= 1'b0;
            TAP_BSCAN_RESET      <= 1'b1;
            TAP_ICE_RESET        <= 1'b1;
        end
        else
        begin
            SLOW_CLOCK           <= slow_lvl;
            USE_MASTER_CLOCK     <= ctrl_q[`RMSC_CTRL_USE_MASTER];
            CLOCK_OUT_IS_GPIO    <= ctrl_q[`RMSC_CTRL_CLKOUT_GPIO];
            CLOCK_OUT_PIN        <= ctrl_q[`RMSC_CTRL_CLKOUT_GPIO] ? 1'b0 : slow_lvl;
            MODE_ONCHIP_OSC      <= mode_q == `RMSC_MODE_ONCHIP_OSC;
            MODE_BSCAN           <= mode_q == `RMSC_MODE_BSCAN;
            MODE_EXT_CLOCK       <= mode_q == `RMSC_MODE_EXT_CLOCK;
            MODE_TEST            <= mode_q == `RMSC_MODE_TEST;
            ICE_MODE             <= ~mode_q[0];
            BSCAN_INSTR_EN       <= mode_q == `RMSC_MODE_BSCAN;
            CORE_ID_NONCOMPLIANT <= ~mode_q[0];
            BOOT_8BIT            <= boot_q;
            OUTPUTS_HIZ          <= tri_q;
            // Test reset only; the external reset never reaches these
            TAP_BSCAN_RESET      <= ~TEST_PORT_RESET_N & port_sel_q;
            TAP_ICE_RESET        <= ~TEST_PORT_RESET_N & ~port_sel_q;
        end
    end

    // ----------------------------------------------------------------
    // AXI4-Lite slave
    // ----------------------------------------------------------------
    reg        aw_got_q;
    reg        w_got_q;
    reg [7:0]  aw_addr_q;
    reg [31:0] w_data_q;
    reg        w_lane0_q;
    wire       aw_take = S_AXI_AWVALID & S_AXI_AWREADY;
    wire       w_take  = S_AXI_WVALID & S_AXI_WREADY;
    wire       have_aw = aw_got_q | aw_take;
    wire       have_w  = w_got_q | w_take;
    wire [7:0] wr_addr = aw_got_q ? aw_addr_q : S_AXI_AWADDR;
    wire [31:0] wr_data = w_got_q ? w_data_q : S_AXI_WDATA;
    wire       wr_lane0 = w_got_q ? w_lane0_q : S_AXI_WSTRB[0];
    wire       wr_fire = have_aw & have_w & ~S_AXI_BVALID;
    wire [1:0] wr_sel  = reg_sel(wr_addr);
    wire [1:0] rd_sel  = reg_sel(S_AXI_ARADDR);

    wire [31:0] status_word = {23'h0, ICE_MODE, in_reset, cause_wd_q, cause_ext_q,
                               port_sel_q, tri_q, boot_q, mode_q};

    // Control register is a peripheral register: any reset clears it
    always @(posedge CLK)
    begin
        if (in_reset)
            ctrl_q <= `RMSC_CTRL_RESET;
        else if (wr_fire && wr_sel == 2'h1 && wr_lane0)
            ctrl_q <= wr_data[`RMSC_CTRL_WIDTH-1:0];
    end

    always @(posedge CLK)
    begin
        if (RESET)
        begin
            aw_got_q      <= 1'b0;
            w_got_q       <= 1'b0;
            aw_addr_q     <= 8'h00;
            w_data_q      <= 32'h0000_0000;
            w_lane0_q     <= 1'b0;
            S_AXI_AWREADY <= 1'b0;
            S_AXI_WREADY  <= 1'b0;
            S_AXI_BVALID  <= 1'b0;
            S_AXI_BRESP   <= `RMSC_RESP_OKAY;
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID  <= 1'b0;
            S_AXI_RRESP   <= `RMSC_RESP_OKAY;
            S_AXI_RDATA   <= 32'h0000_0000;
        end
        else
        begin
            if (aw_take)
            begin
                aw_addr_q <= S_AXI_AWADDR;
            end
            if (w_take)
            begin
                w_data_q  <= S_AXI_WDATA;
                w_lane0_q <= S_AXI_WSTRB[0];
            end
            if (wr_fire)
            begin
                aw_got_q     <= 1'b0;
                w_got_q      <= 1'b0;
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP  <= (wr_sel == 2'h0) ? `RMSC_RESP_SLVERR : `RMSC_RESP_OKAY;
            end
            else
            begin
                aw_got_q <= have_aw;
                w_got_q  <= have_w;
                if (S_AXI_BVALID && S_AXI_BREADY)
                    S_AXI_BVALID <= 1'b0;
            end
            // Ready one cycle after idle, dropped while a write is pending
            S_AXI_AWREADY <= ~have_aw & ~S_AXI_AWREADY & ~S_AXI_BVALID;
            S_AXI_WREADY  <= ~have_w & ~S_AXI_WREADY & ~S_AXI_BVALID;

            if (S_AXI_ARVALID && S_AXI_ARREADY)
            begin
                S_AXI_ARREADY <= 1'b0;
                S_AXI_RVALID  <= 1'b1;
                case (rd_sel)
                    2'h1:
                    begin
                        S_AXI_RDATA <= {29'h0, ctrl_q};
                        S_AXI_RRESP <= `RMSC_RESP_OKAY;
                    end
                    2'h2:
                    begin
                        S_AXI_RDATA <= status_word;
                        S_AXI_RRESP <= `RMSC_RESP_OKAY;
                    end
                    default:
                    begin
                        S_AXI_RDATA <= 32'h0000_0000;
                        S_AXI_RRESP <= `RMSC_RESP_SLVERR;
                    end
                endcase
            end
            else if (S_AXI_RVALID)
            begin
                if (S_AXI_RREADY)
                    S_AXI_RVALID <= 1'b0;
            end
            else
            begin
                S_AXI_ARREADY <= ~S_AXI_ARREADY;
            end
        end
    end

endmodule

`default_nettype wire

// ### bench/rmsc_chk.sv
// Port-level assertions for the reset and mode control block
`timescale 1ns/1ps
`default_nettype none
module rmsc_chk
(
    // Clock and reset pins
    input wire logic CLK,
    input wire logic RESET,
    input wire logic EXT_RESET_N,
    input wire logic TEST_PORT_RESET_N,
    // Reset group
    input wire logic CPU_RESET,
    input wire logic PERIPH_REG_RESET,
    input wire logic EXT_BUS_ADDR_LOW,
    input wire logic PERIPH_IO_FORCE_INPUT,
    input wire logic PERIPH_CLK_EN,
    // Clock output
    input wire logic CLOCK_OUT_PIN,
    input wire logic CLOCK_OUT_IS_GPIO,
    // Modes and test ports
    input wire logic MODE_ONCHIP_OSC,
    input wire logic MODE_BSCAN,
    input wire logic MODE_EXT_CLOCK,
    input wire logic MODE_TEST,
    input wire logic ICE_MODE,
    input wire logic BSCAN_INSTR_EN,
    input wire logic CORE_ID_NONCOMPLIANT,
    input wire logic TAP_BSCAN_RESET,
    input wire logic TAP_ICE_RESET
);
    // Cycles since the reset pin was last low, saturating
    logic [3:0] high_q;
    wire  [3:0] modes = {MODE_TEST, MODE_EXT_CLOCK, MODE_BSCAN, MODE_ONCHIP_OSC};
    always @(posedge CLK)
    begin
        if (!EXT_RESET_N)
            high_q <= 4'h0;
        else if (high_q != 4'hF)
            high_q <= high_q + 4'h1;
    end
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RESET);
    sequence s_release;
        $fell(CPU_RESET);
    endsequence
    chk_ext_entry: assert property (!EXT_RESET_N |-> CPU_RESET)
        else $error("reset group not raised by reset pin");
    chk_group_same: assert property (CPU_RESET == PERIPH_REG_RESET &&
        CPU_RESET == EXT_BUS_ADDR_LOW && CPU_RESET == PERIPH_IO_FORCE_INPUT)
        else $error("reset group outputs disagree");
    chk_pclk_off: assert property (CPU_RESET && $past(CPU_RESET) |-> !PERIPH_CLK_EN)
        else $error("peripheral clock on during reset");
    chk_release_sync: assert property (s_release |-> high_q == 4'hF)
        else $error("reset released too soon after pin rise");
    chk_mode_onehot: assert property ($onehot(modes))
        else $error("mode outputs not one-hot");
    chk_mode_hold: assert property ($changed(modes) |-> high_q <= 4'h4)
        else $error("mode changed without reset release");
    chk_ice_link: assert property (ICE_MODE == CORE_ID_NONCOMPLIANT &&
        ICE_MODE == (MODE_ONCHIP_OSC || MODE_EXT_CLOCK) && BSCAN_INSTR_EN == MODE_BSCAN)
        else $error("emulation and scan selection inconsistent");
    chk_tap_idle: assert property (!$past(RESET) && $past(TEST_PORT_RESET_N)
        |-> !TAP_ICE_RESET && !TAP_BSCAN_RESET)
        else $error("test port reset without test reset pin");
    chk_tap_one: assert property (!$past(RESET) && !$past(TEST_PORT_RESET_N)
        |-> TAP_ICE_RESET ^ TAP_BSCAN_RESET)
        else $error("test reset not routed to exactly one port");
    chk_gpio_low: assert property (CLOCK_OUT_IS_GPIO && $past(CLOCK_OUT_IS_GPIO)
        |-> !CLOCK_OUT_PIN)
        else $error("clock output active while used as line");
endmodule
bind rmsc_top rmsc_chk rmsc_chk_i (.*);
`default_nettype wire

// ### bench/rmsc_board.sv
// Board model: oscillators, reset pins and strap resistors
`timescale 1ns/1ps
`default_nettype none
module rmsc_board
(
    // Clock
    input  wire logic CLK,
    // Oscillators
    output var  logic ONCHIP_OSC_CLK,
    output var  logic OSC_INPUT_PIN,
    // Reset pins
    output var  logic EXT_RESET_N,
    output var  logic TEST_PORT_RESET_N,
    // Mode and strap pins
    output var  logic OP_SELECT0,
    output var  logic OP_SELECT1,
    output var  logic BOOT_WIDTH_STRAP,
    output var  logic TRISTATE_STRAP_N,
    output var  logic TEST_PORT_SELECT
);
    // Different rates show which source feeds the slow clock
    localparam int OSC_HALF = 100;
    localparam int PIN_HALF = 150;
    initial
    begin
        ONCHIP_OSC_CLK = 1'b0;
        OSC_INPUT_PIN = 1'b0;
        EXT_RESET_N = 1'b0;
        TEST_PORT_RESET_N = 1'b0;
        {OP_SELECT0, OP_SELECT1} = 2'h0;
        {BOOT_WIDTH_STRAP, TRISTATE_STRAP_N, TEST_PORT_SELECT} = 3'h2;
    end
    always #(OSC_HALF) ONCHIP_OSC_CLK = ~ONCHIP_OSC_CLK;
    always #(PIN_HALF) OSC_INPUT_PIN = ~OSC_INPUT_PIN;
    task full_reset(input logic [1:0] m, input logic b, input logic t, input logic p);
        @(posedge CLK);
        EXT_RESET_N <= 1'b0;
        TEST_PORT_RESET_N <= 1'b0;
        {OP_SELECT0, OP_SELECT1} <= m;
        {BOOT_WIDTH_STRAP, TRISTATE_STRAP_N, TEST_PORT_SELECT} <= {b, t, p};
        // Twelve cycles of the slower source covers either oscillator
        repeat (12 * PIN_HALF / 5) @(posedge CLK);
        EXT_RESET_N <= 1'b1;
        TEST_PORT_RESET_N <= 1'b1;
    endtask
    task test_reset(input int n);
        @(posedge CLK);
        TEST_PORT_RESET_N <= 1'b0;
        repeat (n) @(posedge CLK);
        TEST_PORT_RESET_N <= 1'b1;
    endtask
    task straps(input logic b, input logic t);
        @(posedge CLK);
        BOOT_WIDTH_STRAP <= b;
        TRISTATE_STRAP_N <= t;
    endtask
endmodule
`default_nettype wire

// ### bench/rmsc_top_test.sv
// Self-checking testbench for the reset and mode control block
`timescale 1ns/1ps
`default_nettype none
`include "rmsc_defs.vh"
module rmsc_top_test;
    logic        CLK, RESET, WDOG_RESET, S_AXI_AWVALID, S_AXI_WVALID;
    logic        S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY;
    logic [7:0]  S_AXI_AWADDR, S_AXI_ARADDR;
    logic [31:0] S_AXI_WDATA, rdat, stat;
    logic [3:0]  S_AXI_WSTRB;
    logic [1:0]  resp;
    wire         EXT_RESET_N, TEST_PORT_RESET_N, OP_SELECT0, OP_SELECT1, OSC_INPUT_PIN;
    wire         ONCHIP_OSC_CLK, BOOT_WIDTH_STRAP, TRISTATE_STRAP_N, TEST_PORT_SELECT;
    wire         S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
    wire [1:0]   S_AXI_BRESP, S_AXI_RRESP;
    wire [31:0]  S_AXI_RDATA;
    wire         CPU_RESET, PERIPH_REG_RESET, EXT_BUS_ADDR_LOW, PERIPH_CLK_EN, SLOW_CLOCK;
    wire         PERIPH_IO_FORCE_INPUT, USE_MASTER_CLOCK, CLOCK_OUT_PIN, CLOCK_OUT_IS_GPIO;
    wire         MODE_ONCHIP_OSC, MODE_BSCAN, MODE_EXT_CLOCK, MODE_TEST, ICE_MODE;
    wire         BSCAN_INSTR_EN, CORE_ID_NONCOMPLIANT, BOOT_8BIT, OUTPUTS_HIZ;
    wire         TAP_BSCAN_RESET, TAP_ICE_RESET;
    wire [3:0]   rst_grp = {CPU_RESET, PERIPH_REG_RESET, EXT_BUS_ADDR_LOW, PERIPH_IO_FORCE_INPUT};
    int          n_errors = 0;
    int          num_checks = 0;
    int          cyc = 0;
    int          n;
    rmsc_top   rmsc_top_i (.*);
    rmsc_board rmsc_board_i (.*);
    initial
    begin
        CLK = 1'b0;
        forever
            #5 CLK = ~CLK;
    end
    // Hang guard, well above the few thousand cycles needed
    always @(posedge CLK)
    begin
        cyc++;
        if (cyc == 10000)
        begin
            n_errors++;
            summarize();
        end
    end
    task summarize;
        $display("checks=%0d errors=%0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge CLK);
        {S_AXI_AWADDR, S_AXI_WDATA} <= {a, d};
        {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY} <= 3'h7;
        do
        begin
            @(posedge CLK);
            if (S_AXI_AWVALID && S_AXI_AWREADY)
                S_AXI_AWVALID <= 1'b0;
            if (S_AXI_WVALID && S_AXI_WREADY)
                S_AXI_WVALID <= 1'b0;
        end
        while (!S_AXI_BVALID);
        r = S_AXI_BRESP;
        S_AXI_BREADY <= 1'b0;
    endtask
    task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge CLK);
        S_AXI_ARADDR <= a;
        {S_AXI_ARVALID, S_AXI_RREADY} <= 2'h3;
        do
        begin
            @(posedge CLK);
            if (S_AXI_ARVALID && S_AXI_ARREADY)
                S_AXI_ARVALID <= 1'b0;
        end
        while (!S_AXI_RVALID);
        {d, r} = {S_AXI_RDATA, S_AXI_RRESP};
        S_AXI_RREADY <= 1'b0;
    endtask
    task wait_rel;
        n = 0;
        while (CPU_RESET !== 1'b0 && n < 400)
        begin
            @(posedge CLK);
            #1;
            n++;
        end
    endtask
    task slow_half(output int h);
        h = 0;
        @(posedge SLOW_CLOCK);
        while (SLOW_CLOCK === 1'b1)
        begin
            @(posedge CLK);
            #1;
            h++;
        end
    endtask
    task boot(input logic [1:0] m, input logic b, input logic t, input logic p);
        int diff;
        int half;
        diff = 0;
        fork
            rmsc_board_i.full_reset(m, b, t, p);
            begin
                repeat (150) @(posedge CLK);
                #1;
                chk({rst_grp, PERIPH_CLK_EN}, 5'h1E);
                repeat (100)
                begin
                    @(posedge CLK);
                    #1;
                    diff += (CLOCK_OUT_PIN !== SLOW_CLOCK);
                end
                chk(diff < 4, 1'b1);
            end
        join
        wait_rel();
        chk(rst_grp, 4'h0);
        chk({MODE_TEST, MODE_EXT_CLOCK, MODE_BSCAN, MODE_ONCHIP_OSC}, 4'h1 << m);
        chk({ICE_MODE, CORE_ID_NONCOMPLIANT, BSCAN_INSTR_EN}, {!m[0], !m[0], m == 2'h1});
        chk({BOOT_8BIT, OUTPUTS_HIZ}, {b, !t});
        rd(`RMSC_ADDR_STATUS, stat, resp);
        chk(stat[4:0], {p, !t, b, m});
        slow_half(half);
        chk(half, m == 2'h2 ? 15 : 10);
        fork
            rmsc_board_i.test_reset(4);
            begin
                repeat (3) @(posedge CLK);
                #1;
                chk({TAP_BSCAN_RESET, TAP_ICE_RESET}, {p, !p});
            end
        join
    endtask
    task s_regs;
        wr(`RMSC_ADDR_CTRL, 32'h0000_0007, resp);
        chk(resp, `RMSC_RESP_OKAY);
        rd(`RMSC_ADDR_CTRL, rdat, resp);
        chk(rdat, 32'h0000_0007);
        chk({USE_MASTER_CLOCK, PERIPH_CLK_EN, CLOCK_OUT_IS_GPIO, CLOCK_OUT_PIN}, 4'hE);
        wr(`RMSC_ADDR_STATUS, 32'hFFFF_FFFF, resp);
        chk(resp, `RMSC_RESP_OKAY);
        rd(`RMSC_ADDR_STATUS, rdat, resp);
        chk(rdat, stat);
        rd(8'h08, rdat, resp);
        chk({resp, rdat[29:0]}, {`RMSC_RESP_SLVERR, 30'h0});
        wr(8'h08, 32'h0, resp);
        chk(resp, `RMSC_RESP_SLVERR);
    endtask
    task s_wdog;
        rmsc_board_i.straps(1'b0, 1'b0);
        @(posedge CLK);
        WDOG_RESET <= 1'b1;
        @(posedge CLK);
        WDOG_RESET <= 1'b0;
        repeat (2) @(posedge CLK);
        #1;
        chk({CPU_RESET, TAP_BSCAN_RESET, TAP_ICE_RESET}, 3'h4);
        wait_rel();
        chk({BOOT_8BIT, OUTPUTS_HIZ}, 2'h2);
        rd(`RMSC_ADDR_CTRL, rdat, resp);
        chk(rdat, 32'h0);
        rd(`RMSC_ADDR_STATUS, rdat, resp);
        chk(rdat[6], 1'b1);
    endtask
    task s_both;
        fork
            rmsc_board_i.full_reset(2'h0, 1'b0, 1'b1, 1'b0);
            begin
                repeat (100) @(posedge CLK);
                WDOG_RESET <= 1'b1;
                @(posedge CLK);
                WDOG_RESET <= 1'b0;
            end
        join
        wait_rel();
        chk({n < 100, BOOT_8BIT}, 2'h2);
        rd(`RMSC_ADDR_STATUS, rdat, resp);
        chk(rdat[5], 1'b1);
    endtask
    initial
    begin
        {RESET, WDOG_RESET, S_AXI_WSTRB} = 6'h2F;
        {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY} = 5'h00;
        {S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA} = 48'h0;
        repeat (3) @(posedge CLK);
        RESET <= 1'b0;
        for (int m = 0; m < 4; m++)
            boot(m[1:0], m[0], m != 1, m[1]);
        s_regs();
        s_wdog();
        s_both();
        summarize();
    end
endmodule
`default_nettype wire
